// [include/hltm_pkg.sv]
// Shared constants and types for the hardware-limit timer mode controller.
package hltm_pkg;

  // Counter width of the documented timer.
  localparam int HLTM_CNT_W = 8;

  // Register decode width and word offsets on the bus.
  localparam int          HLTM_ADDR_W     = 12;
  localparam logic [11:0] HLTM_OFS_CTRL   = 12'h000;
  localparam logic [11:0] HLTM_OFS_PERIOD = 12'h004;
  localparam logic [11:0] HLTM_OFS_COUNT  = 12'h008;
  localparam logic [11:0] HLTM_OFS_STATUS = 12'h00c;

  // Field positions in the control register.
  localparam int HLTM_CTRL_ON_POS   = 0;
  localparam int HLTM_CTRL_MODE_POS = 1;
  localparam int HLTM_CTRL_SRC_POS  = 6;

  // Field positions in the status register.
  localparam int HLTM_STAT_ON_POS  = 0;
  localparam int HLTM_STAT_RUN_POS = 1;
  localparam int HLTM_STAT_ERS_POS = 2;

  // Reset values.
  localparam logic [7:0] HLTM_PERIOD_RST = 8'hff;
  localparam logic [4:0] HLTM_MODE_RST   = 5'h00;
  localparam logic [3:0] HLTM_SRC_RST    = 4'h0;

  // Mode codes: free-running period modes.
  localparam logic [4:0] HLTM_M_FREE_SOFT    = 5'h00;
  localparam logic [4:0] HLTM_M_FREE_GATE_HI = 5'h01;
  localparam logic [4:0] HLTM_M_FREE_GATE_LO = 5'h02;
  localparam logic [4:0] HLTM_M_FREE_ANY_CLR = 5'h03;
  localparam logic [4:0] HLTM_M_FREE_RIS_CLR = 5'h04;
  localparam logic [4:0] HLTM_M_FREE_FAL_CLR = 5'h05;
  localparam logic [4:0] HLTM_M_FREE_LO_CLR  = 5'h06;
  localparam logic [4:0] HLTM_M_FREE_HI_CLR  = 5'h07;
  // Mode codes: one-shot modes.
  localparam logic [4:0] HLTM_M_OS_SOFT      = 5'h08;
  localparam logic [4:0] HLTM_M_OS_RIS       = 5'h09;
  localparam logic [4:0] HLTM_M_OS_FAL       = 5'h0a;
  localparam logic [4:0] HLTM_M_OS_ANY       = 5'h0b;
  localparam logic [4:0] HLTM_M_OS_RIS_RIS   = 5'h0c;
  localparam logic [4:0] HLTM_M_OS_FAL_FAL   = 5'h0d;
  localparam logic [4:0] HLTM_M_OS_RIS_LO    = 5'h0e;
  localparam logic [4:0] HLTM_M_OS_FAL_HI    = 5'h0f;
  // Mode codes: mono-stable modes.
  localparam logic [4:0] HLTM_M_MS_RIS       = 5'h11;
  localparam logic [4:0] HLTM_M_MS_FAL       = 5'h12;

  // Control register fields.
  typedef struct packed {
    logic [3:0] src;
    logic [4:0] mode;
    logic       on;
  } hltm_ctrl_t;

  // Edges seen on the external reset signal.
  typedef struct packed {
    logic rise;
    logic fall;
  } hltm_edge_t;

  // Phase of the edge- or software-started modes.
  typedef enum logic {HLTM_PH_IDLE, HLTM_PH_RUN} hltm_phase_t;

endpackage

// [src/hltm_edge_det.sv]
// Edge detector for the selected external reset signal.
`timescale 1ns/1ps
`default_nettype none
module hltm_edge_det
  import hltm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              level,
  output hltm_pkg::hltm_edge_t   edges
);

  // Previous level and a flag that a valid sample exists.
  typedef struct packed {
    logic prev;
    logic primed;
  } hltm_edst_t;

  hltm_edst_t s;       // Registered state.
  hltm_edst_t next_s;  // Next state.

  // Edges are reported only after one sample, so a high level at reset is no edge.
  always_comb begin
    edges.rise = s.primed & level & ~s.prev;
    edges.fall = s.primed & ~level & s.prev;
  end

  // Sample the level while the clock enable is high.
  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.prev   = level;
      next_s.primed = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule
`default_nettype wire

// [src/hltm_timer.sv]
// Mode controller and counter of the hardware-limit timer with AHB-Lite registers.
// Function
// - Software mode: run bit alone gates counting.
// - Gate high: count while run and signal high.
// - Gate low: count while run and signal low.
// - Edge reset modes clear counter on edges.
// - Low level holds counter clear, stops it.
// - High level holds counter clear, stops it.
// - One-shot started by software run bit.
// - One-shot started by run plus chosen edge.
// - One-shot edge start; same edge later clears.
// - One-shot edge start, opposite level clears.
// - Mono-stable started by edge; code 10000 reserved.
// - After run clears, new edge needed.
// - One-shot match clears run, stops at zero.
// - Mono-stable match stops at zero, run stays.
// - Source select picks pin or on-chip signal.
`timescale 1ns/1ps
`default_nettype none
module hltm_timer
  import hltm_pkg::*;
#(
  parameter int CNT_W = hltm_pkg::HLTM_CNT_W
)(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              ext_reset_pin,
  input  wire logic [14:0]       ext_reset_onchip,
  output logic [CNT_W-1:0]       count_value,
  output logic                   period_match,
  output logic                   timer_on
);

  // Refuse counter widths that do not fit the 32-bit register words.
  if (CNT_W < 1 || CNT_W > 32) begin : g_bad_width
    $error("hltm_timer: CNT_W must lie between 1 and 32");
  end

  // All state of the block.
  typedef struct packed {
    logic                   pin_s1;   // First stage of the pin synchroniser.
    logic                   pin_s2;   // Second stage of the pin synchroniser.
    hltm_ctrl_t             ctrl;     // Run bit, mode and source select.
    logic [CNT_W-1:0]       period;   // Period limit.
    logic [CNT_W-1:0]       count;    // Counter value.
    hltm_phase_t            phase;    // Started or waiting, for started modes.
    logic                   match;    // One-cycle period-match pulse.
    logic                   wr_pend;  // A write data phase is due.
    logic [HLTM_ADDR_W-1:0] wr_addr;  // Address of the pending write.
    logic [31:0]            rdata;    // Read data for the data phase.
  } hltm_state_t;

  // Reset value of the state.
  localparam hltm_state_t HLTM_STATE_RST = '{
    pin_s1:  1'b0,
    pin_s2:  1'b0,
    ctrl:    '{src: HLTM_SRC_RST, mode: HLTM_MODE_RST, on: 1'b0},
    period:  CNT_W'(HLTM_PERIOD_RST),
    count:   '0,
    phase:   HLTM_PH_IDLE,
    match:   1'b0,
    wr_pend: 1'b0,
    wr_addr: '0,
    rdata:   '0
  };

  logic [1:0]  rst_q;    // Reset release synchroniser.
  logic        rst_n;    // Synchronised reset, active low.
  hltm_state_t s;        // Registered state.
  hltm_state_t next_s;   // Next state.
  logic        ers;      // Selected external reset signal.
  hltm_edge_t  edges;    // Edges of the selected signal.
  logic        any_edge; // Either edge.
  logic        gate;     // Counter may advance this cycle.
  logic        clr;      // Counter is cleared this cycle.
  logic        start;    // Started mode begins counting.
  logic        started;  // Started modes: in the run phase.
  logic        one_shot; // Mode belongs to the one-shot class.
  logic        mono;     // Mode belongs to the mono-stable class.
  logic        addr_ok;  // Address phase accepted.

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Source 0 is the synchronised pin, the others come from on-chip logic.
  always_comb begin
    if (s.ctrl.src == 4'h0) begin
      ers = s.pin_s2;
    end else begin
      ers = ext_reset_onchip[s.ctrl.src - 4'h1];
    end
  end

  // Edge detection of the selected signal.
  hltm_edge_det u_edge (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .level (ers),
    .edges (edges)
  );

  assign any_edge = edges.rise | edges.fall;
  assign started  = (s.phase == HLTM_PH_RUN);

  // Decode the mode into gate, clear and start terms.
  always_comb begin
    gate     = 1'b0;
    clr      = 1'b0;
    start    = 1'b0;
    one_shot = 1'b0;
    mono     = 1'b0;
    case (s.ctrl.mode)
      HLTM_M_FREE_SOFT: begin
        gate = s.ctrl.on;
      end
      HLTM_M_FREE_GATE_HI: begin
        gate = s.ctrl.on & ers;
      end
      HLTM_M_FREE_GATE_LO: begin
        gate = s.ctrl.on & ~ers;
      end
      HLTM_M_FREE_ANY_CLR: begin
        gate = s.ctrl.on;
        clr  = any_edge;
      end
      HLTM_M_FREE_RIS_CLR: begin
        gate = s.ctrl.on;
        clr  = edges.rise;
      end
      HLTM_M_FREE_FAL_CLR: begin
        gate = s.ctrl.on;
        clr  = edges.fall;
      end
      HLTM_M_FREE_LO_CLR: begin
        gate = s.ctrl.on & ers;
        clr  = ~ers;
      end
      HLTM_M_FREE_HI_CLR: begin
        gate = s.ctrl.on & ~ers;
        clr  = ers;
      end
      HLTM_M_OS_SOFT: begin
        one_shot = 1'b1;
        start    = s.ctrl.on;
      end
      HLTM_M_OS_RIS: begin
        one_shot = 1'b1;
        start    = s.ctrl.on & edges.rise;
      end
      HLTM_M_OS_FAL: begin
        one_shot = 1'b1;
        start    = s.ctrl.on & edges.fall;
      end
      HLTM_M_OS_ANY: begin
        one_shot = 1'b1;
        start    = s.ctrl.on & any_edge;
      end
      HLTM_M_OS_RIS_RIS: begin
        one_shot = 1'b1;
        start    = s.ctrl.on & edges.rise;
        clr      = started & edges.rise;
      end
      HLTM_M_OS_FAL_FAL: begin
        one_shot = 1'b1;
        start    = s.ctrl.on & edges.fall;
        clr      = started & edges.fall;
      end
      HLTM_M_OS_RIS_LO: begin
        one_shot = 1'b1;
        start    = s.ctrl.on & edges.rise;
        clr      = ~ers;
      end
      HLTM_M_OS_FAL_HI: begin
        one_shot = 1'b1;
        start    = s.ctrl.on & edges.fall;
        clr      = ers;
      end
      HLTM_M_MS_RIS: begin
        mono  = 1'b1;
        start = s.ctrl.on & edges.rise;
      end
      HLTM_M_MS_FAL: begin
        mono  = 1'b1;
        start = s.ctrl.on & edges.fall;
      end
      default: begin
        // Reserved codes, 10000 among them, never count.
        gate = 1'b0;
      end
    endcase
    // Started modes advance only in their run phase.
    if (one_shot | mono) begin
      gate = s.ctrl.on & started;
    end
  end

  // An address phase is taken when the slave is selected and the bus is ready.
  assign addr_ok = hsel & hready & htrans[1];

  // Next-state logic: synchroniser, counter, phase and register writes.
  always_comb begin
    next_s        = s;
    next_s.match  = 1'b0;
    next_s.pin_s1 = ext_reset_pin;
    next_s.pin_s2 = s.pin_s1;
    // Phase of the started modes.
    if (!s.ctrl.on) begin
      next_s.phase = HLTM_PH_IDLE;
    end else if ((one_shot | mono) && !started && start) begin
      next_s.phase = HLTM_PH_RUN;
    end
    // Counter.
    if (clr) begin
      next_s.count = '0;
    end else if (gate) begin
      if (s.count == s.period) begin
        next_s.count = '0;
        next_s.match = 1'b1;
        if (one_shot) begin
          next_s.ctrl.on = 1'b0;
          next_s.phase   = HLTM_PH_IDLE;
        end
        if (mono) begin
          next_s.phase = HLTM_PH_IDLE;
        end
      end else begin
        next_s.count = s.count + 1'b1;
      end
    end
    // Data phase of a write; a software write of the run bit wins over the hardware clear.
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      case (s.wr_addr)
        HLTM_OFS_CTRL: begin
          next_s.ctrl.on   = hwdata[HLTM_CTRL_ON_POS];
          next_s.ctrl.mode = hwdata[HLTM_CTRL_MODE_POS +: 5];
          next_s.ctrl.src  = hwdata[HLTM_CTRL_SRC_POS +: 4];
          if (hwdata[HLTM_CTRL_MODE_POS +: 5] != s.ctrl.mode) begin
            next_s.phase = HLTM_PH_IDLE;
          end
        end
        HLTM_OFS_PERIOD: begin
          next_s.period = hwdata[CNT_W-1:0];
        end
        default: begin
          // Read-only and unmapped words ignore writes.
          next_s.wr_pend = 1'b0;
        end
      endcase
    end
    // Address phase: note a write, or fetch read data from the updated state.
    if (addr_ok) begin
      next_s.wr_pend = hwrite;
      next_s.wr_addr = haddr[HLTM_ADDR_W-1:0];
      if (!hwrite) begin
        next_s.rdata = '0;
        case (haddr[HLTM_ADDR_W-1:0])
          HLTM_OFS_CTRL: begin
            next_s.rdata[HLTM_CTRL_ON_POS]          = next_s.ctrl.on;
            next_s.rdata[HLTM_CTRL_MODE_POS +: 5]   = next_s.ctrl.mode;
            next_s.rdata[HLTM_CTRL_SRC_POS +: 4]    = next_s.ctrl.src;
          end
          HLTM_OFS_PERIOD: begin
            next_s.rdata[CNT_W-1:0] = next_s.period;
          end
          HLTM_OFS_COUNT: begin
            next_s.rdata[CNT_W-1:0] = next_s.count;
          end
          HLTM_OFS_STATUS: begin
            next_s.rdata[HLTM_STAT_ON_POS]  = next_s.ctrl.on;
            next_s.rdata[HLTM_STAT_RUN_POS] = gate;
            next_s.rdata[HLTM_STAT_ERS_POS] = ers;
          end
          default: begin
            // Unmapped words read as zero.
            next_s.rdata = '0;
          end
        endcase
      end
    end
    // A low clock enable freezes every bit of state.
    if (!ce) begin
      next_s = s;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= HLTM_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // The slave never waits and always answers OKAY.
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign hrdata       = s.rdata;
  assign count_value  = s.count;
  assign period_match = s.match;
  assign timer_on     = s.ctrl.on;

endmodule
`default_nettype wire

// [dv/hltm_timer_chk.sv]
// Port checker for the hardware-limit timer, bound into the timer top.
`timescale 1ns/1ps
`default_nettype none
module hltm_timer_chk #(
  parameter int CNT_W = 8
)(
  input wire logic             clk,
  input wire logic             rstn,
  input wire logic             ce,
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic [31:0]      hwdata,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  input wire logic [31:0]      hrdata,
  input wire logic [CNT_W-1:0] count_value,
  input wire logic             period_match,
  input wire logic             timer_on
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // A read address phase taken by the slave.
  sequence rd_taken_s;
    hsel && hready && htrans[1] && !hwrite && ce;
  endsequence
  // A whole control write: address phase, then its data phase.
  sequence ctrl_wr_s;
    hsel && hready && htrans[1] && hwrite && ce && haddr[11:0] == 12'h000 ##1 ce;
  endsequence
  hready_a: assert property (hreadyout) else $error("wait state inserted");
  okay_a: assert property (!hresp) else $error("error response");
  unmapped_rd_a: assert property (rd_taken_s ##0 haddr[11:4] != 8'h00 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  on_write_a: assert property (ctrl_wr_s |=> timer_on == $past(hwdata[0]))
    else $error("run bit not taken from write");
  match_zero_a: assert property (period_match |-> count_value == '0)
    else $error("match without reload to zero");
  count_step_a: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 1'b1 || count_value == '0)
    else $error("counter jumped");
  count_hold_a: assert property (!timer_on && count_value != '1 |=>
    count_value != $past(count_value) + 1'b1)
    else $error("counted with run bit clear");
  freeze_a: assert property (!ce |=> $stable(count_value) && $stable(timer_on))
    else $error("state moved with clock enable low");
endmodule
bind hltm_timer hltm_timer_chk #(.CNT_W(CNT_W)) u_chk (.clk(clk), .rstn(rstn), .ce(ce),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .count_value(count_value), .period_match(period_match), .timer_on(timer_on));
`default_nettype wire

// [dv/hltm_ers_model.sv]
// Model of the on-chip logic that drives the selectable reset sources.
`timescale 1ns/1ps
`default_nettype none
module hltm_ers_model (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   lvl,
  output logic [14:0] onchip
);
  // Source one follows the request a clock later; the unused ones toggle every cycle
  // so that no stale level can pass for a selected one.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) onchip <= 15'h0;
    else onchip <= {~onchip[14:1], lvl};
  end
endmodule
`default_nettype wire

// [dv/hltm_timer_tb.sv]
// Self-checking bench for the hardware-limit timer mode controller.
`timescale 1ns/1ps
`default_nettype none
module hltm_timer_tb;
  import hltm_pkg::*;
  logic        clk = 0, rstn = 0, ce = 1, hsel = 0, hwrite = 0, lvl = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, period_match, timer_on;
  logic [14:0] onchip;
  logic [7:0]  count_value, c0;
  int          bad_count = 0, n_compared = 0, cyc = 0, n;
  // Far-side model of the on-chip reset sources.
  hltm_ers_model u_src (.clk(clk), .rstn(rstn), .lvl(lvl), .onchip(onchip));
  hltm_timer dut (.clk(clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_reset_pin(lvl),
    .ext_reset_onchip(onchip), .count_value(count_value), .period_match(period_match),
    .timer_on(timer_on));
  initial forever #25 clk = ~clk;
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // One single AHB-Lite transfer; read data is taken at the data phase edge.
  task ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= {20'h0, a}; hwrite <= w; htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00; hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d); ahb(a, 1'b1, d); endtask
  task rd_chk(input logic [11:0] a, input logic [31:0] e); ahb(a, 1'b0, 32'h0); chk(rd, e); endtask
  task cyc_n(input int k); repeat (k) @(posedge clk); endtask
  // Reset values, read-only and unmapped places, every mode code and the source field.
  task t_regs;
    rd_chk(HLTM_OFS_CTRL, 32'h0);
    rd_chk(HLTM_OFS_PERIOD, 32'hff);
    wr(HLTM_OFS_COUNT, 32'h55);
    rd_chk(HLTM_OFS_COUNT, 32'h0);
    rd_chk(12'h010, 32'h0);
    for (int m = 0; m < 32; m++) begin
      wr(HLTM_OFS_CTRL, 32'(m) << 1);
      rd_chk(HLTM_OFS_CTRL, 32'(m) << 1);
    end
    lvl <= 1'b1;
    wr(HLTM_OFS_CTRL, 32'h040);
    cyc_n(4);
    rd_chk(HLTM_OFS_STATUS, 32'h4);
    lvl <= 1'b0;
  endtask
  // Software mode: counts per clock, wraps at the period, freezes with ce low, stops.
  task t_free;
    wr(HLTM_OFS_PERIOD, 32'h3);
    wr(HLTM_OFS_CTRL, 32'h1);
    lvl <= 1'b1;
    cyc_n(3);
    n = 0;
    repeat (12) begin
      @(posedge clk);
      n += int'(period_match === 1'b1);
      chk(32'(count_value <= 8'h3), 32'h1);
    end
    chk(n, 3);
    ce <= 1'b0;
    // Let one frozen edge pass so the reference is the held value.
    @(posedge clk);
    c0 = count_value;
    cyc_n(4);
    chk(count_value, c0);
    ce <= 1'b1;
    wr(HLTM_OFS_PERIOD, 32'hff);
    wr(HLTM_OFS_CTRL, 32'h0);
    // The data phase edge still counts; take the reference one edge later.
    @(posedge clk);
    c0 = count_value;
    cyc_n(4);
    chk(count_value, c0);
  endtask
  // Gates: high on source one, low on source one, high on the pin.
  task t_gate;
    logic [31:0] cfg [3];
    logic        stp [3];
    cfg = '{32'h043, 32'h045, 32'h003};
    stp = '{1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      lvl <= stp[i];
      wr(HLTM_OFS_CTRL, cfg[i]);
      cyc_n(4);
      c0 = count_value;
      cyc_n(4);
      chk(count_value, c0);
      lvl <= ~stp[i];
      cyc_n(5);
      c0 = count_value;
      cyc_n(3);
      chk(count_value, 8'(c0 + 8'h3));
    end
  endtask
  // Rising edge clears a running count; low level holds it cleared.
  task t_clear;
    lvl <= 1'b0;
    wr(HLTM_OFS_CTRL, 32'h049);
    cyc_n(8);
    lvl <= 1'b1;
    cyc_n(4);
    chk(32'(count_value < 8'h5), 32'h1);
    wr(HLTM_OFS_CTRL, 32'h04d);
    lvl <= 1'b0;
    cyc_n(4);
    chk(count_value, 8'h0);
    cyc_n(3);
    chk(count_value, 8'h0);
  endtask
  // One-shot from software: at the period the run bit drops and the count parks at zero.
  task t_oneshot;
    wr(HLTM_OFS_PERIOD, 32'h5);
    wr(HLTM_OFS_CTRL, 32'h051);
    for (int i = 0; i < 60 && timer_on !== 1'b0; i++) @(posedge clk);
    chk(timer_on, 1'b0);
    cyc_n(3);
    chk(count_value, 8'h0);
  endtask
  // Mono-stable on rising edges: waits for an edge, stops at zero keeping the run bit.
  task t_mono;
    wr(HLTM_OFS_CTRL, 32'h063);
    cyc_n(4);
    chk(count_value, 8'h0);
    lvl <= 1'b1;
    for (int i = 0; i < 60 && period_match !== 1'b1; i++) @(posedge clk);
    chk(period_match, 1'b1);
    cyc_n(3);
    chk(timer_on, 1'b1);
    chk(count_value, 8'h0);
    lvl <= 1'b0;
    cyc_n(2);
    lvl <= 1'b1;
    cyc_n(5);
    chk(32'(count_value != 8'h0), 32'h1);
  endtask
  // Reserved codes hold the counter where it stands.
  task t_resv;
    wr(HLTM_OFS_CTRL, 32'h021);
    @(posedge clk);
    c0 = count_value;
    cyc_n(4);
    chk(count_value, c0);
    wr(HLTM_OFS_CTRL, 32'h03f);
    @(posedge clk);
    c0 = count_value;
    cyc_n(4);
    chk(count_value, c0);
  endtask
  // High level clear, and three edge-started one-shot modes: rise with rise clear, rise with low clear, and fall alone.
  task t_edges;
    wr(HLTM_OFS_CTRL, 32'h04f);
    cyc_n(3);
    chk(count_value, 8'h0);
    lvl <= 1'b0;
    cyc_n(5);
    chk(count_value, 8'h3);
    wr(HLTM_OFS_PERIOD, 32'hff);
    wr(HLTM_OFS_CTRL, 32'h059);
    @(posedge clk);
    c0 = count_value;
    lvl <= 1'b1;
    cyc_n(6);
    chk(count_value, 8'(c0 + 8'h3));
    lvl <= 1'b0;
    cyc_n(3);
    lvl <= 1'b1;
    cyc_n(3);
    chk(count_value, 8'h0);
    wr(HLTM_OFS_CTRL, 32'h05d);
    lvl <= 1'b0;
    cyc_n(4);
    chk(count_value, 8'h0);
    lvl <= 1'b1;
    cyc_n(5);
    chk(count_value, 8'h2);
    wr(HLTM_OFS_CTRL, 32'h055);
    @(posedge clk);
    c0 = count_value;
    cyc_n(3);
    chk(count_value, c0);
    lvl <= 1'b0;
    cyc_n(5);
    chk(count_value, 8'(c0 + 8'h2));
  endtask
  initial begin
    cyc_n(16);
    rstn <= 1'b1;
    cyc_n(3);
    t_regs;
    t_free;
    t_gate;
    t_clear;
    t_oneshot;
    t_mono;
    t_resv;
    t_edges;
    tally_and_finish;
  end
endmodule
`default_nettype wire
